// file: hdl/tx_power_override.sv
// transmit-path power override register bank with axi4-lite slave
// assumes one clock; modem power requests come from same-clock logic
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tx_power_override
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address
	input wire logic [tx_power_pkg::addr_w-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// write data
	input wire logic [tx_power_pkg::data_w-1:0] s_axi_wdata,
	input wire logic [tx_power_pkg::strb_w-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read address
	input wire logic [tx_power_pkg::addr_w-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// read data
	output logic [tx_power_pkg::data_w-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// modem power requests, high asks for power-up
	input wire logic modem_amp_on,
	input wire logic modem_upmixer_on,
	input wire logic modem_converter_on,
	// circuit power states, high means powered; converter_disable is high when the converter is forced off
	output logic amp_power_on,
	output logic upmixer_power_on,
	output logic converter_power_on,
	output logic converter_disable
);
	import tx_power_pkg::*;

	// ----------------------------------------
	// power-state decode
	// ----------------------------------------
	function automatic logic power_state(input logic off_ctl,
		input logic on_ctl, input logic modem_req);
		if (!on_ctl)
			power_state = 1'b1;
		else if (!off_ctl)
			power_state = 1'b0;
		else
			power_state = modem_req;
	endfunction

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	typedef enum logic [1:0] {
		sel_down = 2'h0,
		sel_up = 2'h1,
		sel_status = 2'h2,
		sel_none = 2'h3
	} reg_sel_t;

	function automatic reg_sel_t decode_addr(
		input logic [addr_w-1:0] addr);
		if (addr == off_power_down)
			decode_addr = sel_down;
		else if (addr == off_power_up)
			decode_addr = sel_up;
		else if (addr == off_status)
			decode_addr = sel_status;
		else
			decode_addr = sel_none;
	endfunction

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [reg_w-1:0] power_down_r;
	logic [reg_w-1:0] power_up_r;
	logic [addr_w-1:0] awaddr_r;
	logic [data_w-1:0] wdata_r;
	logic [strb_w-1:0] wstrb_r;
	logic aw_held_r;
	logic w_held_r;
	logic [1:0] bresp_r;
	logic bvalid_r;
	logic [data_w-1:0] rdata_r;
	logic [1:0] rresp_r;
	logic rvalid_r;
	logic amp_on_r;
	logic mix_on_r;
	logic conv_on_r;
	logic conv_dis_r;

	logic do_write;
	logic [1:0] mix_off_code;
	logic [1:0] mix_on_code;
	logic mix_valid;
	reg_sel_t wr_sel;
	reg_sel_t rd_sel;

	assign s_axi_awready = !aw_held_r && !bvalid_r;
	assign s_axi_wready = !w_held_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign do_write = aw_held_r && w_held_r && !bvalid_r;
	assign wr_sel = decode_addr(awaddr_r);
	assign rd_sel = decode_addr(s_axi_araddr);

	// ----------------------------------------
	// write channel capture
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_r <= 1'b0;
			awaddr_r <= '0;
		end
		else if (s_axi_awvalid && s_axi_awready)
		begin
			aw_held_r <= 1'b1;
			awaddr_r <= s_axi_awaddr;
		end
		else if (do_write)
			aw_held_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_held_r <= 1'b0;
			wdata_r <= '0;
			wstrb_r <= '0;
		end
		else if (s_axi_wvalid && s_axi_wready)
		begin
			w_held_r <= 1'b1;
			wdata_r <= s_axi_wdata;
			wstrb_r <= s_axi_wstrb;
		end
		else if (do_write)
			w_held_r <= 1'b0;
	end

	// ----------------------------------------
	// register write and response
	// ----------------------------------------
	assign mix_off_code = wdata_r[bit_mix_hi:bit_mix_lo];
	assign mix_valid = (mix_off_code == mix_code_set) ||
		(mix_off_code == mix_code_clr);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			power_down_r <= rst_power_down;
		else if (do_write && wr_sel == sel_down && wstrb_r[0] &&
			mix_valid)
			power_down_r[bit_amp:0] <= wdata_r[bit_amp:0];
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			power_up_r <= rst_power_up;
		else if (do_write && wr_sel == sel_up && wstrb_r[0] &&
			mix_valid)
			power_up_r[bit_amp:0] <= wdata_r[bit_amp:0];
	end

	// ----------------------------------------
	// write response
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bvalid_r <= 1'b0;
		else if (do_write)
			bvalid_r <= 1'b1;
		else if (bvalid_r && s_axi_bready)
			bvalid_r <= 1'b0;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			bresp_r <= resp_okay;
		else if (do_write)
		begin
			if (wr_sel == sel_none)
				bresp_r <= resp_decerr;
			else if (wr_sel == sel_status)
				bresp_r <= resp_slverr;
			else if (wstrb_r[0] && !mix_valid)
				bresp_r <= resp_slverr;
			else
				bresp_r <= resp_okay;
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			rvalid_r <= 1'b0;
		else if (s_axi_arvalid && s_axi_arready)
			rvalid_r <= 1'b1;
		else if (rvalid_r && s_axi_rready)
			rvalid_r <= 1'b0;
	end

	// ----------------------------------------
	// read data
	// ----------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rdata_r <= '0;
			rresp_r <= resp_okay;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rresp_r <= resp_okay;
			rdata_r <= '0;
			if (rd_sel == sel_down)
				rdata_r[reg_w-1:0] <= power_down_r;
			else if (rd_sel == sel_up)
				rdata_r[reg_w-1:0] <= power_up_r;
			else if (rd_sel == sel_status)
				rdata_r[bit_amp:bit_converter] <= {conv_dis_r, conv_on_r,
					mix_on_r, amp_on_r};
			else
				rresp_r <= resp_decerr;
		end
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;

	// ----------------------------------------
	// power outputs
	// ----------------------------------------
	assign mix_on_code = power_up_r[bit_mix_hi:bit_mix_lo];

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			amp_on_r <= 1'b0;
		else
			amp_on_r <= power_state(power_down_r[bit_amp],
				power_up_r[bit_amp], modem_amp_on);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mix_on_r <= 1'b0;
		else
			mix_on_r <= power_state(
				power_down_r[bit_mix_hi:bit_mix_lo] == mix_code_set,
				mix_on_code == mix_code_set, modem_upmixer_on);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			conv_on_r <= 1'b0;
		else
			conv_on_r <= power_state(power_down_r[bit_converter],
				power_up_r[bit_converter], modem_converter_on);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			conv_dis_r <= 1'b1;
		else
			conv_dis_r <= power_up_r[bit_converter] &&
				!power_down_r[bit_converter];
	end

	assign amp_power_on = amp_on_r;
	assign upmixer_power_on = mix_on_r;
	assign converter_power_on = conv_on_r;
	assign converter_disable = conv_dis_r;

endmodule // tx_power_override
`default_nettype wire

// file: hdl/tx_power_pkg.sv
// constants for the transmit-path power override register bank
// assumes a 32-bit axi4-lite slave with one word per register
package tx_power_pkg;
	localparam int addr_w = 12;
	localparam int data_w = 32;
	localparam int strb_w = 4;
	// register byte addresses
	localparam logic [11:0] off_power_down = 12'h000;
	localparam logic [11:0] off_power_up = 12'h004;
	localparam logic [11:0] off_status = 12'h008;
	// field positions
	localparam int bit_converter = 0;
	localparam int bit_mix_lo = 1;
	localparam int bit_mix_hi = 2;
	localparam int bit_amp = 3;
	localparam int reg_w = 8;
	// reset values
	localparam logic [7:0] rst_power_down = 8'hd0;
	localparam logic [7:0] rst_power_up = 8'hdf;
	// meaningful up-mixer codes
	localparam logic [1:0] mix_code_set = 2'h3;
	localparam logic [1:0] mix_code_clr = 2'h0;
	// axi responses
	localparam logic [1:0] resp_okay = 2'h0;
	localparam logic [1:0] resp_slverr = 2'h2;
	localparam logic [1:0] resp_decerr = 2'h3;
endpackage

// file: tb/tx_power_override_assertions.sv
// port checks for tx_power_override
// assumes one clock, sync active-low reset
`timescale 1ns/1ps
`default_nettype none
module tx_power_override_chk
(
	input wire logic aclk, aresetn, s_axi_arvalid, s_axi_arready,
	input wire logic s_axi_rvalid, s_axi_rready, s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_bresp,
	input wire logic modem_converter_on, converter_power_on,
	input wire logic converter_disable, amp_power_on
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_off_disables: assert property (
		converter_disable |-> !converter_power_on) else $error("dis on");
	a_rst_amp: assert property (
		$rose(aresetn) |=> !amp_power_on) else $error("amp on");
	a_rst_conv: assert property (
		$rose(aresetn) |=> converter_disable) else $error("conv on");
	a_follow_modem: assert property (
		!converter_power_on && !converter_disable
		|-> !$past(modem_converter_on)) else $error("conv off");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b");
	a_ar_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("ar");
endmodule // tx_power_override_chk
bind tx_power_override tx_power_override_chk u_chk (.*);
`default_nettype wire

// file: tb/tb.sv
// bench for tx_power_override over axi4-lite
// assumes design and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tx_power_pkg::*;
	logic aclk = 0, aresetn = 0;
	logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
	logic s_axi_arvalid = 0, s_axi_rready = 1, s_axi_awready;
	logic s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic modem_amp_on = 0, modem_upmixer_on = 0, modem_converter_on = 0;
	logic amp_power_on, upmixer_power_on, converter_power_on;
	logic converter_disable;
	int n_errors = 0, checks = 0, cyc = 0;
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
$display("ERROR %s exp %h got %h", nm, e, g); end end
	tx_power_override u_tx_power_override (.*);
	always #50 aclk = ~aclk;
	task automatic give_verdict;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_errors++;
			give_verdict;
		end
	end
	task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
		end
		while (s_axi_bvalid !== 1'b1);
		`CHK("bresp", r, s_axi_bresp)
	endtask
	task automatic rd(logic [11:0] a, logic [31:0] d, logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do
		begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
		end
		while (s_axi_rvalid !== 1'b1);
		`CHK("rdata", d, s_axi_rdata)
		`CHK("rresp", r, s_axi_rresp)
	endtask
	// program both fields, set modem, check pins and status
	task automatic mode(logic [31:0] dn, up, logic [2:0] m, logic [3:0] e);
		wr(off_power_down, dn, resp_okay);
		wr(off_power_up, up, resp_okay);
		{modem_amp_on, modem_upmixer_on, modem_converter_on} <= m;
		repeat (3) @(posedge aclk);
		`CHK("pins", e, {converter_disable, converter_power_on,
			upmixer_power_on, amp_power_on})
		rd(off_status, {28'h0, e}, resp_okay);
	endtask
	initial
	begin
		repeat (6) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(off_status, 32'h8, resp_okay);
		rd(off_power_down, 32'hd0, resp_okay);
		rd(off_power_up, 32'hdf, resp_okay);
		mode(32'hf, 32'hf, 3'h7, 4'b0111);
		mode(32'hf, 32'hf, 3'h0, 4'b0000);
		mode(32'hf, 32'hf, 3'h5, 4'b0101);
		mode(32'hf, 32'hf, 3'h2, 4'b0010);
		mode(32'h0, 32'hf, 3'h7, 4'b1000);
		mode(32'hf, 32'h0, 3'h0, 4'b0111);
		mode(32'h0, 32'h0, 3'h0, 4'b0111);
		mode(32'h6, 32'hf, 3'h7, 4'b1010);
		wr(off_power_down, 32'h2, resp_slverr);
		rd(off_power_down, 32'hd6, resp_okay);
		rd(12'h00c, 32'h0, resp_decerr);
		wr(off_status, 32'hf, resp_slverr);
		wr(off_power_up, 32'h4, resp_slverr);
		rd(off_power_up, 32'hdf, resp_okay);
		// mid-run reset: outputs fall back to forced-down state
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		`CHK("rst pins", 4'b1000, {converter_disable, converter_power_on,
			upmixer_power_on, amp_power_on})
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(off_power_down, 32'hd0, resp_okay);
		rd(off_status, 32'h8, resp_okay);
		give_verdict;
	end
endmodule // tb
`default_nettype wire
